// File: common/amc_pkg.sv
// Purpose: Constants for the converter control-word decoder and sequencer
// Assumes: 16-bit control word shifted MSB first, latched on chip select rise
// Notes:   Field positions, codes and cycle counts live here only
package amc_pkg;
   localparam int WORD_W       = 16;
   localparam int CNT_W        = 17;
   // Control-word field positions
   localparam int BIT_XFER     = 15;
   localparam int BIT_LEN_HI   = 12;
   localparam int BIT_LEN_LO   = 9;
   localparam int BIT_DIV4     = 8;
   localparam int BIT_DIV2     = 7;
   localparam int BIT_CHAN     = 4;
   localparam int BIT_GAIN     = 3;
   localparam int BIT_NULL     = 2;
   localparam int BIT_OSC_PD   = 1;
   localparam int BIT_ANA_PD   = 0;
   // Conversion-length codes and cycle counts
   localparam logic [3:0] LEN_CODE_10K  = 4'h9;
   localparam logic [3:0] LEN_CODE_20K  = 4'h3;
   localparam logic [3:0] LEN_CODE_81K  = 4'h6;
   localparam logic [3:0] LEN_CODE_102K = 4'h0;
   localparam logic [CNT_W-1:0] LEN_10K  = 17'd10240;
   localparam logic [CNT_W-1:0] LEN_20K  = 17'd20480;
   localparam logic [CNT_W-1:0] LEN_81K  = 17'd81920;
   localparam logic [CNT_W-1:0] LEN_102K = 17'd102400;
   // Reset value of the shift and control registers
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   // Analog mux selections
   typedef enum logic [2:0] {
      AMC_MUX_CH1   = 3'h0,
      AMC_MUX_CH2   = 3'h1,
      AMC_MUX_N1    = 3'h2,
      AMC_MUX_N2    = 3'h3,
      AMC_MUX_REFN  = 3'h4,
      AMC_MUX_REFPN = 3'h5
   } amc_mux_t;
   // Conversion kinds
   typedef enum logic [1:0] {
      AMC_KIND_SIGNAL = 2'h0,
      AMC_KIND_NULL   = 2'h1,
      AMC_KIND_GAIN   = 2'h3
   } amc_kind_t;
   // Sequencer states, Gray along idle-run-done
   typedef enum logic [1:0] {
      AMC_ST_IDLE = 2'b00,
      AMC_ST_RUN  = 2'b01,
      AMC_ST_DONE = 2'b11
   } amc_state_t;
endpackage

// File: core/amc_ctrl.sv
// Purpose: Serial control-word capture, mode decode and conversion sequencing
// Assumes: Serial pins come from outside the clock domain; result from modulator
// Notes:   Modulator itself is outside; this block steers it and counts cycles
// Functional notes
// - Channel bit high selects second input pair, low selects first.
// - Both cal fields zero with transfer set starts a signal conversion.
// - Null only: negative input of selected channel on both sides, null conversion.
// - Gain and null: ignore channel, negative reference on both, null conversion.
// - Gain only: references applied, gain conversion from null, result to cal register.
// - Transfer bit low discards word, keeps configuration, starts nothing.
// - Length field picks 10240, 20480, 81920 or 102400 cycles.
// - Divider bits pass, halve or quarter the oversampling clock.
// - Bit 15 high loads lower fifteen bits and starts conversion.
// - Gain field at bit three, null field at bit two.
// - Internal registers clear to zero at power-up; chip select synchronisers preset to one.
module amc_ctrl (
   // Clock and reset
   input  wire logic                     i_mclk,
   input  wire logic                     i_rst_n,
   // Serial port
   input  wire logic                     i_cs_n,
   input  wire logic                     i_sclk,
   input  wire logic                     i_din,
   output logic                          o_dout,
   // Modulator result
   input  wire logic [amc_pkg::WORD_W-1:0] i_result,
   // Converter steering
   output amc_pkg::amc_mux_t             o_mux_sel,
   output amc_pkg::amc_kind_t            o_conv_kind,
   output logic                          o_osc_tick,
   output logic                          o_busy_n,
   output logic                          o_conv_start,
   output logic                          o_null_store,
   output logic                          o_cal_store,
   output logic                          o_analog_powerdown,
   output logic                          o_oscillator_powerdown
);
   localparam int W = amc_pkg::WORD_W;

   // Three-stage synchronisers for the serial pins
   logic [2:0] cs_sync_reg, sclk_sync_reg, din_sync_reg;
   logic [2:0] cs_sync_next, sclk_sync_next, din_sync_next;
   logic       cs_q_reg, sclk_q_reg;
   logic       cs_q_next, sclk_q_next;

   always_comb begin
      cs_sync_next   = {cs_sync_reg[1:0], i_cs_n};
      sclk_sync_next = {sclk_sync_reg[1:0], i_sclk};
      din_sync_next  = {din_sync_reg[1:0], i_din};
      cs_q_next      = (cs_sync_reg[2] == cs_sync_reg[1]) ? cs_sync_reg[2] : cs_q_reg;
      sclk_q_next    = (sclk_sync_reg[2] == sclk_sync_reg[1]) ? sclk_sync_reg[2] : sclk_q_reg;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         // Pin idle levels, so no false edge follows reset
         cs_sync_reg   <= 3'h7;
         sclk_sync_reg <= 3'h0;
         din_sync_reg  <= 3'h0;
         cs_q_reg      <= 1'b1;
         sclk_q_reg    <= 1'b0;
      end else begin
         cs_sync_reg   <= cs_sync_next;
         sclk_sync_reg <= sclk_sync_next;
         din_sync_reg  <= din_sync_next;
         cs_q_reg      <= cs_q_next;
         sclk_q_reg    <= sclk_q_next;
      end
   end

   // Settled pin levels and edges; serial edges count only while selected
   logic       cs_stable;
   logic       sclk_stable;
   logic       cs_rise;
   logic       sclk_rise;
   logic       sclk_fall;
   assign cs_stable   = (cs_sync_reg[2] == cs_sync_reg[1]) ? cs_sync_reg[2] : cs_q_reg;
   assign sclk_stable = (sclk_sync_reg[2] == sclk_sync_reg[1]) ? sclk_sync_reg[2] : sclk_q_reg;
   assign cs_rise     = cs_stable & ~cs_q_reg;
   assign sclk_rise   = sclk_stable & ~sclk_q_reg & ~cs_q_reg;
   assign sclk_fall   = ~sclk_stable & sclk_q_reg & ~cs_q_reg;

   // Shift register, control register and sequencer state
   logic [W-1:0]          shift_reg, shift_next;
   logic [W-2:0]          ctrl_reg, ctrl_next;
   logic                  dout_reg, dout_next;
   amc_pkg::amc_state_t   st_reg, st_next;
   logic [amc_pkg::CNT_W-1:0] cnt_reg, cnt_next, len_cyc;
   logic                  start_reg, start_next;
   logic                  nst_reg, nst_next, cst_reg, cst_next;
   logic                  tick;
   logic                  gain_f;
   logic                  null_f;

   assign gain_f = ctrl_reg[amc_pkg::BIT_GAIN];
   assign null_f = ctrl_reg[amc_pkg::BIT_NULL];

   // Unlisted length codes fall back to the longest length
   always_comb begin
      case (ctrl_reg[amc_pkg::BIT_LEN_HI:amc_pkg::BIT_LEN_LO])
         amc_pkg::LEN_CODE_10K: len_cyc = amc_pkg::LEN_10K;
         amc_pkg::LEN_CODE_20K: len_cyc = amc_pkg::LEN_20K;
         amc_pkg::LEN_CODE_81K: len_cyc = amc_pkg::LEN_81K;
         default:               len_cyc = amc_pkg::LEN_102K;
      endcase
   end

   always_comb begin
      shift_next = shift_reg;
      ctrl_next  = ctrl_reg;
      dout_next  = dout_reg;
      st_next    = st_reg;
      cnt_next   = cnt_reg;
      start_next = 1'b0;
      nst_next   = 1'b0;
      cst_next   = 1'b0;
      if (sclk_rise) begin
         shift_next = {shift_reg[W-2:0], din_sync_reg[2]};
      end
      if (sclk_fall) begin
         dout_next = shift_reg[W-1];
      end
      case (st_reg)
         amc_pkg::AMC_ST_IDLE: begin
            cnt_next = '0;
         end
         amc_pkg::AMC_ST_RUN: begin
            if (tick) begin
               cnt_next = cnt_reg + 17'h00001;
               if (cnt_reg == len_cyc - 17'h00001) begin
                  st_next = amc_pkg::AMC_ST_DONE;
               end
            end
         end
         amc_pkg::AMC_ST_DONE: begin
            shift_next = i_result;
            dout_next  = i_result[W-1];
            nst_next   = (o_conv_kind == amc_pkg::AMC_KIND_NULL);
            cst_next   = (o_conv_kind == amc_pkg::AMC_KIND_GAIN);
            st_next    = amc_pkg::AMC_ST_IDLE;
         end
         default: st_next = amc_pkg::AMC_ST_IDLE;
      endcase
      // Word taken at chip select rise; a new conversion aborts the old one
      if (cs_rise) begin
         if (shift_reg[amc_pkg::BIT_XFER]) begin
            ctrl_next  = shift_reg[W-2:0];
            st_next    = amc_pkg::AMC_ST_RUN;
            cnt_next   = '0;
            start_next = 1'b1;
            // A run ending in this very cycle is aborted too, so no stray store
            nst_next   = 1'b0;
            cst_next   = 1'b0;
         end // else word discarded
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shift_reg <= amc_pkg::WORD_RST;
         ctrl_reg  <= amc_pkg::WORD_RST[W-2:0];
         dout_reg  <= 1'b0;
         st_reg    <= amc_pkg::AMC_ST_IDLE;
         cnt_reg   <= '0;
         start_reg <= 1'b0;
         nst_reg   <= 1'b0;
         cst_reg   <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         ctrl_reg  <= ctrl_next;
         dout_reg  <= dout_next;
         st_reg    <= st_next;
         cnt_reg   <= cnt_next;
         start_reg <= start_next;
         nst_reg   <= nst_next;
         cst_reg   <= cst_next;
      end
   end

   // Mode and mux decode
   always_comb begin
      if (gain_f && null_f) begin
         o_mux_sel   = amc_pkg::AMC_MUX_REFN;
         o_conv_kind = amc_pkg::AMC_KIND_NULL;
      end else if (gain_f) begin
         o_mux_sel   = amc_pkg::AMC_MUX_REFPN;
         o_conv_kind = amc_pkg::AMC_KIND_GAIN;
      end else if (null_f) begin
         o_mux_sel   = ctrl_reg[amc_pkg::BIT_CHAN] ? amc_pkg::AMC_MUX_N2 : amc_pkg::AMC_MUX_N1;
         o_conv_kind = amc_pkg::AMC_KIND_NULL;
      end else begin
         o_mux_sel   = ctrl_reg[amc_pkg::BIT_CHAN] ? amc_pkg::AMC_MUX_CH2 : amc_pkg::AMC_MUX_CH1;
         o_conv_kind = amc_pkg::AMC_KIND_SIGNAL;
      end
   end

   // Divider free-runs; a new word does not realign its phase
   amc_osc_div u_div (
      .i_mclk (i_mclk),
      .i_rst_n(i_rst_n),
      .i_div2 (ctrl_reg[amc_pkg::BIT_DIV2]),
      .i_div4 (ctrl_reg[amc_pkg::BIT_DIV4]),
      .o_tick (tick)
   );

   // Busy decodes state, so it falls with the start pulse
   assign o_osc_tick             = tick;
   assign o_busy_n               = (st_reg == amc_pkg::AMC_ST_IDLE);
   assign o_conv_start           = start_reg;
   assign o_null_store           = nst_reg;
   assign o_cal_store            = cst_reg;
   assign o_dout                 = dout_reg;
   assign o_analog_powerdown     = ctrl_reg[amc_pkg::BIT_ANA_PD];
   assign o_oscillator_powerdown = ctrl_reg[amc_pkg::BIT_OSC_PD];
endmodule

// File: core/amc_osc_div.sv
// Purpose: Oversampling clock enable from the input clock by 1, 2 or 4
// Assumes: Divide ratio code is stable while converting
// Notes:   Produces a one-cycle tick rather than a derived clock
module amc_osc_div (
   // Clock and reset
   input  wire logic i_mclk,
   input  wire logic i_rst_n,
   // Control
   input  wire logic i_div2,
   input  wire logic i_div4,
   // Tick out
   output logic      o_tick
);
   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   logic       tick_next;
   logic       tick_reg;

   // Both divider bits set is not allowed; treated as divide by four
   always_comb begin
      cnt_next  = cnt_reg + 2'h1;
      tick_next = 1'b0;
      if (i_div4) begin
         tick_next = (cnt_reg == 2'h3);
      end else if (i_div2) begin
         tick_next = cnt_reg[0];
         cnt_next  = {1'b0, ~cnt_reg[0]};
      end else begin
         tick_next = 1'b1;
         cnt_next  = 2'h0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg  <= 2'h0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign o_tick = tick_reg;
endmodule

// File: sim/amc_ctrl_chk.sv
// Purpose: Port checks for the control-word decoder
// Assumes: One clock domain, bound to amc_ctrl
// Notes:   Mux and kind are combinational decodes
module amc_ctrl_chk (
   // Watched ports
   input wire logic          i_mclk,
   input wire logic          i_rst_n,
   input wire logic          i_cs_n,
   input wire logic          o_busy_n,
   input wire logic          o_conv_start,
   input wire logic          o_null_store,
   input wire logic          o_cal_store,
   input amc_pkg::amc_mux_t  o_mux_sel,
   input amc_pkg::amc_kind_t o_conv_kind
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   start_busy_a: assert property (o_conv_start |-> !o_busy_n) else $error("busy high at start");
   start_once_a: assert property (o_conv_start |=> !o_conv_start) else $error("start too long");
   start_cs_a: assert property (o_conv_start |-> i_cs_n && $past(i_cs_n, 2))
      else $error("start while selected");
   busy_fall_a: assert property ($fell(o_busy_n) |-> o_conv_start) else $error("busy fell alone");
   store_end_a: assert property (o_null_store || o_cal_store |-> o_busy_n && !$past(o_busy_n))
      else $error("store not at end");
   sig_mux_a: assert property (o_conv_kind == amc_pkg::AMC_KIND_SIGNAL |-> o_mux_sel <= amc_pkg::AMC_MUX_CH2)
      else $error("bad signal mux");
   null_mux_a: assert property (o_conv_kind == amc_pkg::AMC_KIND_NULL |-> o_mux_sel inside {[3'h2:3'h4]})
      else $error("bad null mux");
   gain_mux_a: assert property (o_conv_kind == amc_pkg::AMC_KIND_GAIN |-> o_mux_sel == amc_pkg::AMC_MUX_REFPN)
      else $error("bad gain mux");
   null_kind_a: assert property (o_null_store |-> o_conv_kind == amc_pkg::AMC_KIND_NULL)
      else $error("null store kind");
   cal_kind_a: assert property (o_cal_store |-> o_conv_kind == amc_pkg::AMC_KIND_GAIN)
      else $error("cal store kind");
   cover property (o_null_store);
   cover property (o_cal_store);
   cover property (o_conv_start);
endmodule
bind amc_ctrl amc_ctrl_chk i_amc_ctrl_chk (.i_mclk, .i_rst_n, .i_cs_n, .o_busy_n, .o_conv_start,
   .o_null_store, .o_cal_store, .o_mux_sel, .o_conv_kind);

// File: sim/amc_host_model.sv
// Purpose: Host writing control words over the serial link
// Assumes: Each serial level held at least four input-clock cycles
// Notes:   Data line inverted between frames so stale bits show
module amc_host_model (
   // Clock
   input  wire logic i_mclk,
   // Serial link
   output logic      o_cs_n,
   output logic      o_sclk,
   output logic      o_din,
   input  wire logic i_dout
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_din  = 1'b0;
   end
   // Whole word, unused bits zero as given by caller
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      for (int i = 15; i >= 0; i--) begin
         @(negedge i_mclk);
         o_cs_n = 1'b0;
         o_din  = w[i];
         repeat (4) @(negedge i_mclk);
         r[i]   = i_dout;
         o_sclk = 1'b1;
         repeat (4) @(negedge i_mclk);
         o_sclk = 1'b0;
      end
      repeat (4) @(negedge i_mclk);
      o_cs_n = 1'b1;
      o_din  = ~o_din;
      repeat (8) @(negedge i_mclk);
   endtask
endmodule

// File: sim/testbench.sv
// Purpose: Self-checking bench for the control-word decoder
// Assumes: Inputs change at falling edges, outputs read there
// Notes:   81920 and 102400 lengths left out to keep the run short
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk, i_rst_n, i_cs_n, i_sclk, i_din, o_dout, o_osc_tick, o_busy_n;
   logic o_conv_start, o_null_store, o_cal_store, o_analog_powerdown, o_oscillator_powerdown;
   logic [15:0] i_result, rd, last;
   amc_pkg::amc_mux_t  o_mux_sel;
   amc_pkg::amc_kind_t o_conv_kind;
   int bad_count = 0, n_checks = 0, n_start = 0, n_null = 0, n_cal = 0, n_tick = 0;
   logic [15:0] words [8] = '{16'h9200, 16'h9210, 16'h9204, 16'h9214, 16'h920c, 16'h921c, 16'h9208, 16'h9203};
   logic [4:0]  decs [8]  = '{5'h00, 5'h01, 5'h0a, 5'h0b, 5'h0c, 5'h0c, 5'h1d, 5'h00};
   amc_ctrl i_amc_ctrl (.i_mclk, .i_rst_n, .i_cs_n, .i_sclk, .i_din, .o_dout, .i_result, .o_mux_sel,
      .o_conv_kind, .o_osc_tick, .o_busy_n, .o_conv_start, .o_null_store, .o_cal_store,
      .o_analog_powerdown, .o_oscillator_powerdown);
   amc_host_model i_amc_host_model (.i_mclk, .o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_din(i_din), .i_dout(o_dout));
   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end
   // Ticks restart at each start, so an aborted run never leaks in
   always @(negedge i_mclk) begin
      n_start += int'(o_conv_start === 1'b1);
      n_null  += int'(o_null_store === 1'b1);
      n_cal   += int'(o_cal_store === 1'b1);
      if (o_conv_start === 1'b1) n_tick = 0;
      else if (o_busy_n === 1'b0 && o_osc_tick === 1'b1) n_tick++;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic send(input logic [15:0] w);
      int s;
      s = n_start;
      i_amc_host_model.xfer(w, rd);
      repeat (6) @(negedge i_mclk);
      check(16'(n_start - s), 16'(w[15]));
   endtask
   task automatic rate(input logic [15:0] w, input int div);
      int t;
      send(w);
      t = 0;
      repeat (400) begin
         @(negedge i_mclk);
         t += int'(o_osc_tick === 1'b1);
      end
      check(16'(t), 16'(400 / div));
   endtask
   task automatic run_len(input logic [15:0] w, input int len, input logic rd_chk);
      int nn, nc;
      nn = n_null;
      nc = n_cal;
      send(w);
      if (rd_chk) check(rd, last);
      for (int c = 0; c < 45000 && o_busy_n !== 1'b1; c++) @(negedge i_mclk);
      @(negedge i_mclk);
      check(16'(n_tick >= len - 1 && n_tick <= len + 1), 16'h1);
      check(16'(n_null - nn), 16'(w[2]));
      check(16'(n_cal - nc), 16'(w[3:2] == 2'b10));
      last = i_result;
      i_result = ~i_result;
   endtask
   initial begin
      i_rst_n = 1'b0;
      i_result = 16'ha5c3;
      repeat (8) @(negedge i_mclk);
      check(16'({o_dout, o_busy_n, o_conv_start}), 16'h2);
      check(16'({o_conv_kind, o_mux_sel}), 16'h00);
      i_rst_n = 1'b1;
      repeat (4) @(negedge i_mclk);
      send(16'h9200);
      check(rd, 16'h0000);
      for (int k = 0; k < 8; k++) begin
         send(words[k]);
         check(16'({o_conv_kind, o_mux_sel}), 16'(decs[k]));
         check(16'({o_oscillator_powerdown, o_analog_powerdown}), 16'(words[k][1:0]));
      end
      send(16'h0014);
      check(16'({o_conv_kind, o_mux_sel, o_analog_powerdown}), 16'h01);
      rate(16'h9200, 1);
      rate(16'h9280, 2);
      rate(16'h9300, 4);
      run_len(16'h920c, 10240, 1'b0);
      run_len(16'h9208, 10240, 1'b1);
      run_len(16'h9214, 10240, 1'b1);
      run_len(16'h9210, 10240, 1'b1);
      run_len(16'h860c, 20480, 1'b1);
      complete_run();
   end
   // Expected run is near 66000 cycles
   initial begin
      repeat (90000) @(negedge i_mclk);
      bad_count++;
      complete_run();
   end
endmodule
